// *** common/dfr_defs.svh ***
// Offsets, reset values and option codes of the fault reaction block.
// Assumes the includer uses them with 18-bit byte addresses.
`ifndef DFR_DEFS_SVH
`define DFR_DEFS_SVH

// ****************************************
// Widths
// ****************************************
`define DFR_AW        18
`define DFR_DW        32

// ****************************************
// Register indices, byte address = 4 * index
// ****************************************
`define DFR_IDX_DEV   16'h3700
`define DFR_IDX_LIM   16'h3701
`define DFR_IDX_EEP   16'h4012
`define DFR_IDX_HWC   16'h4013
`define DFR_IDX_IST   16'h3800
`define DFR_IDX_IMSK  16'h3801
`define DFR_IDX_CTL   16'h3802
`define DFR_IDX_LPOS  16'h3803

// ****************************************
// Reset values
// ****************************************
`define DFR_RST_CODE  16'hffff
`define DFR_RST_HWC   32'h0000_0000

// ****************************************
// Option codes
// ****************************************
`define DFR_C_DISCARD 16'hfffe
`define DFR_C_NONE    16'hffff
`define DFR_C_OFF     16'h0000
`define DFR_C_SLOW    16'h0001
`define DFR_C_QUICK   16'h0002
`define DFR_C_QSLOW   16'h0005
`define DFR_C_QQUICK  16'h0006

// ****************************************
// Status bits and bus answers
// ****************************************
`define DFR_ST_DEV    0
`define DFR_ST_LIM    1
`define DFR_ST_DONE   2
`define DFR_ST_W      3
`define DFR_CTL_REL   0
`define DFR_OKAY      2'b00
`define DFR_SLVERR    2'b10

`endif

// *** common/dfr_pkg.sv ***
// Types of the fault reaction block.
// Assumes dfr_defs.svh is on the include path.
`include "dfr_defs.svh"

package dfr_pkg;

   typedef enum logic [1:0]
   {
      ACT_NONE  = 2'b00,
      ACT_OFF   = 2'b01,
      ACT_SLOW  = 2'b10,
      ACT_QUICK = 2'b11
   } dfr_act_type;

   typedef enum logic [1:0]
   {
      PSM_NONE = 2'b00,
      PSM_QSA  = 2'b01,
      PSM_SOD  = 2'b10
   } dfr_psm_type;

   typedef enum logic [1:0]
   {
      FSM_IDLE = 2'b00,
      FSM_RUN  = 2'b01
   } dfr_fsm_type;

   typedef struct packed
   {
      logic                aw_got;
      logic [`DFR_AW-1:0]  awaddr;
      logic                w_got;
      logic [`DFR_DW-1:0]  wdata;
      logic [3:0]          wstrb;
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [1:0]          rresp;
      logic [`DFR_DW-1:0]  rdata;
      logic [15:0]         dev_code;
      logic [15:0]         lim_code;
      logic [31:0]         hw_cfg;
      logic [`DFR_ST_W-1:0] ist;
      logic [`DFR_ST_W-1:0] imsk;
      logic                irq;
      dfr_fsm_type         fsm;
      dfr_act_type         act;
      dfr_psm_type         fin;
      logic                stage_off;
      logic                brake_slow;
      logic                brake_quick;
      logic                psm_vld;
      dfr_psm_type         psm;
      logic [31:0]         lim_pos;
      logic                lim_pos_vld;
   } dfr_state_type;

endpackage

// *** verilog/dfr_top.sv ***
// Fault reaction selection with an AXI4-Lite register slave.
// Assumes fault events, ramp done and positions come from logic on
// i_clk_sys; the power state machine and ramps live outside.
//
// Summary of operation
// - Deviation error runs the deviation option reaction
// - Deviation codes: none, off, slow, quick
// - Limit trip: latch position, warn, quick stop
// - Limit code -2 discards position, no reaction
// - Limit code -1 only records position
// - Limit codes 0,1,2 end Switch On Disabled
// - Limit codes 5,6 brake, end Quick Stop
// - Both option codes reset FFFF, read/write
// - EEPROM capacity read-only, zero if absent
// - Hardware config word writable, resets zero
`timescale 1ns/1ns
`include "dfr_defs.svh"

module dfr_top
(
   // Clock, reset, enable
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_reset,
   input  wire logic                 i_clk_en,
   // AXI4-Lite write address
   input  wire logic [`DFR_AW-1:0]   i_awaddr,
   input  wire logic                 i_awvalid,
   output logic                      o_awready,
   // AXI4-Lite write data
   input  wire logic [`DFR_DW-1:0]   i_wdata,
   input  wire logic [3:0]           i_wstrb,
   input  wire logic                 i_wvalid,
   output logic                      o_wready,
   // AXI4-Lite write response
   output logic [1:0]                o_bresp,
   output logic                      o_bvalid,
   input  wire logic                 i_bready,
   // AXI4-Lite read address
   input  wire logic [`DFR_AW-1:0]   i_araddr,
   input  wire logic                 i_arvalid,
   output logic                      o_arready,
   // AXI4-Lite read data
   output logic [`DFR_DW-1:0]        o_rdata,
   output logic [1:0]                o_rresp,
   output logic                      o_rvalid,
   input  wire logic                 i_rready,
   // Fault sources
   input  wire logic                 i_dev_err,
   input  wire logic                 i_lim_trip,
   input  wire logic [31:0]          i_lim_pos,
   input  wire logic                 i_ramp_done,
   input  wire logic [31:0]          i_eeprom_size,
   // Drive reaction
   output logic                      o_stage_off,
   output logic                      o_brake_slow,
   output logic                      o_brake_quick,
   output logic                      o_psm_vld,
   output logic [1:0]                o_psm_state,
   output logic                      o_warn,
   output logic [31:0]               o_lim_pos,
   output logic                      o_lim_pos_vld,
   // Interrupt
   output logic                      o_irq
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [`DFR_AW-1:0] addr_of(input logic [15:0] idx);
      addr_of = {idx, 2'b00};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      merge = r;
   endfunction

   // Unknown codes fall back to no reaction
   function automatic dfr_pkg::dfr_act_type dev_act(input logic [15:0] c);
      case (c)
         `DFR_C_OFF:   dev_act = dfr_pkg::ACT_OFF;
         `DFR_C_SLOW:  dev_act = dfr_pkg::ACT_SLOW;
         `DFR_C_QUICK: dev_act = dfr_pkg::ACT_QUICK;
         default:      dev_act = dfr_pkg::ACT_NONE;
      endcase
   endfunction

   function automatic dfr_pkg::dfr_act_type lim_act(input logic [15:0] c);
      case (c)
         `DFR_C_OFF:    lim_act = dfr_pkg::ACT_OFF;
         `DFR_C_SLOW,
         `DFR_C_QSLOW:  lim_act = dfr_pkg::ACT_SLOW;
         `DFR_C_QUICK,
         `DFR_C_QQUICK: lim_act = dfr_pkg::ACT_QUICK;
         default:       lim_act = dfr_pkg::ACT_NONE;
      endcase
   endfunction

   // ****************************************
   // State
   // ****************************************
   dfr_pkg::dfr_state_type s_r;
   dfr_pkg::dfr_state_type s_nxt;

   always_comb
   begin
      logic [`DFR_AW-1:0]  wa;
      logic [31:0]         rd;
      logic                rok;
      logic [31:0]         mw;
      logic [`DFR_ST_W-1:0] set;
      logic [`DFR_ST_W-1:0] clr;
      logic                rel;
      dfr_pkg::dfr_act_type la;
      wa  = '0;
      rd  = '0;
      rok = 1'b0;
      mw  = '0;
      set = '0;
      clr = '0;
      rel = 1'b0;
      la  = lim_act(s_r.lim_code);
      s_nxt = s_r;
      s_nxt.psm_vld = 1'b0;

      // ****************************************
      // Write channel, address and data in either order
      // ****************************************
      if (s_r.awready && i_awvalid)
      begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = i_awaddr;
      end
      if (s_r.wready && i_wvalid)
      begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = i_wdata;
         s_nxt.wstrb = i_wstrb;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
      begin
         wa  = s_r.awaddr;
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = `DFR_OKAY;
         case (wa)
            addr_of(`DFR_IDX_DEV):
            begin
               mw = merge({16'h0000, s_r.dev_code}, s_r.wdata, s_r.wstrb);
               s_nxt.dev_code = mw[15:0];
            end
            addr_of(`DFR_IDX_LIM):
            begin
               mw = merge({16'h0000, s_r.lim_code}, s_r.wdata, s_r.wstrb);
               s_nxt.lim_code = mw[15:0];
            end
            addr_of(`DFR_IDX_HWC):
               s_nxt.hw_cfg = merge(s_r.hw_cfg, s_r.wdata,
                  s_r.wstrb);
            addr_of(`DFR_IDX_IST):
            begin
               mw  = merge('0, s_r.wdata, s_r.wstrb);
               clr = mw[`DFR_ST_W-1:0];
            end
            addr_of(`DFR_IDX_IMSK):
            begin
               mw         = merge('0, s_r.wdata, s_r.wstrb);
               s_nxt.imsk = mw[`DFR_ST_W-1:0];
            end
            addr_of(`DFR_IDX_CTL):
               rel = s_r.wstrb[0] && s_r.wdata[`DFR_CTL_REL];
            addr_of(`DFR_IDX_EEP),
            addr_of(`DFR_IDX_LPOS):
               s_nxt.bresp = `DFR_OKAY; // Read-only, write dropped
            default:
               s_nxt.bresp = `DFR_SLVERR;
         endcase
      end
      if (s_r.bvalid && i_bready)
      begin
         s_nxt.bvalid = 1'b0;
      end
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

      // ****************************************
      // Read channel, one cycle from address to data
      // ****************************************
      if (s_r.arready && i_arvalid)
      begin
         rok = 1'b1;
         case (i_araddr)
            addr_of(`DFR_IDX_DEV):  rd = {16'h0000, s_r.dev_code};
            addr_of(`DFR_IDX_LIM):  rd = {16'h0000, s_r.lim_code};
            addr_of(`DFR_IDX_EEP):  rd = i_eeprom_size;
            addr_of(`DFR_IDX_HWC):  rd = s_r.hw_cfg;
            addr_of(`DFR_IDX_IST):  rd = 32'(s_r.ist);
            addr_of(`DFR_IDX_IMSK): rd = 32'(s_r.imsk);
            addr_of(`DFR_IDX_CTL):
               rd = {20'h00000, s_r.lim_pos_vld, s_r.psm_vld,
                     s_r.fin, s_r.act, s_r.fsm, s_r.stage_off,
                     s_r.brake_quick, s_r.brake_slow, 1'b0};
            addr_of(`DFR_IDX_LPOS): rd = s_r.lim_pos;
            default:                rok = 1'b0;
         endcase
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata  = rd;
         s_nxt.rresp  = rok ? `DFR_OKAY : `DFR_SLVERR;
      end
      else if (s_r.rvalid && i_rready)
      begin
         s_nxt.rvalid = 1'b0;
      end
      s_nxt.arready = !s_nxt.rvalid;

      // ****************************************
      // Fault reaction
      // ****************************************
      if (rel)
      begin
         s_nxt.stage_off = 1'b0;
      end
      if (i_dev_err)
      begin
         set[`DFR_ST_DEV] = 1'b1;
      end
      if (i_lim_trip)
      begin
         set[`DFR_ST_LIM] = 1'b1; // Drives the warning bit
         if (s_r.lim_code == `DFR_C_DISCARD)
         begin
            s_nxt.lim_pos_vld = 1'b0;
         end
         else
         begin
            s_nxt.lim_pos     = i_lim_pos;
            s_nxt.lim_pos_vld = 1'b1;
         end
      end
      case (s_r.fsm)
         dfr_pkg::FSM_IDLE:
         begin
            // Limit trip with a reacting code wins a tie: it also moves the power state
            if (i_lim_trip && la != dfr_pkg::ACT_NONE)
            begin
               s_nxt.fsm     = dfr_pkg::FSM_RUN;
               s_nxt.act     = la;
               s_nxt.psm_vld = 1'b1;
               s_nxt.psm     = dfr_pkg::PSM_QSA;
               s_nxt.fin     = (s_r.lim_code == `DFR_C_QSLOW ||
                                s_r.lim_code == `DFR_C_QQUICK) ?
                               dfr_pkg::PSM_QSA :
                               dfr_pkg::PSM_SOD;
            end
            else if (i_dev_err && dev_act(s_r.dev_code) !=
                     dfr_pkg::ACT_NONE)
            begin
               s_nxt.fsm = dfr_pkg::FSM_RUN;
               s_nxt.act = dev_act(s_r.dev_code);
               s_nxt.fin = dfr_pkg::PSM_SOD;
            end
         end
         dfr_pkg::FSM_RUN:
         begin
            s_nxt.brake_slow  = s_r.act == dfr_pkg::ACT_SLOW;
            s_nxt.brake_quick = s_r.act == dfr_pkg::ACT_QUICK;
            // Off acts at once; braking waits for the ramp end
            if (s_r.act == dfr_pkg::ACT_OFF || i_ramp_done)
            begin
               s_nxt.stage_off   = s_r.act == dfr_pkg::ACT_OFF ||
                                   s_r.fin == dfr_pkg::PSM_SOD;
               s_nxt.brake_slow  = 1'b0;
               s_nxt.brake_quick = 1'b0;
               s_nxt.psm_vld     = 1'b1;
               s_nxt.psm         = s_r.fin;
               s_nxt.act         = dfr_pkg::ACT_NONE;
               s_nxt.fsm         = dfr_pkg::FSM_IDLE;
               set[`DFR_ST_DONE] = 1'b1;
            end
         end
         default:
            s_nxt.fsm = dfr_pkg::FSM_IDLE;
      endcase

      // ****************************************
      // Interrupt, a new event beats its own clear
      // ****************************************
      s_nxt.ist = (s_r.ist & ~clr) | set;
      s_nxt.irq = |(s_nxt.ist & s_nxt.imsk);
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         s_r          <= '0;
         s_r.dev_code <= `DFR_RST_CODE;
         s_r.lim_code <= `DFR_RST_CODE;
         s_r.hw_cfg   <= `DFR_RST_HWC;
         s_r.fsm      <= dfr_pkg::FSM_IDLE;
         s_r.act      <= dfr_pkg::ACT_NONE;
         s_r.fin      <= dfr_pkg::PSM_NONE;
         s_r.psm      <= dfr_pkg::PSM_NONE;
      end
      else if (i_clk_en)
      begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign o_awready     = s_r.awready;
   assign o_wready      = s_r.wready;
   assign o_bresp       = s_r.bresp;
   assign o_bvalid      = s_r.bvalid;
   assign o_arready     = s_r.arready;
   assign o_rdata       = s_r.rdata;
   assign o_rresp       = s_r.rresp;
   assign o_rvalid      = s_r.rvalid;
   assign o_stage_off   = s_r.stage_off;
   assign o_brake_slow  = s_r.brake_slow;
   assign o_brake_quick = s_r.brake_quick;
   assign o_psm_vld     = s_r.psm_vld;
   assign o_psm_state   = s_r.psm;
   assign o_warn        = s_r.ist[`DFR_ST_LIM];
   assign o_lim_pos     = s_r.lim_pos;
   assign o_lim_pos_vld = s_r.lim_pos_vld;
   assign o_irq         = s_r.irq;

endmodule

// *** test/dfr_top_checker.sv ***
// Port checks of the fault reaction block.
// Assumes one clock domain; the bench drops the clock enable only when idle.
`timescale 1ns/1ns

module dfr_top_checker
(
   // Clock, reset, register bus
   input wire logic        i_clk_sys, i_reset, i_awvalid, o_awready,
   input wire logic        i_wvalid, o_wready, o_bvalid, i_bready,
   input wire logic        i_arvalid, o_arready, o_rvalid, i_rready,
   input wire logic [1:0]  o_bresp,
   input wire logic [31:0] o_rdata,
   // Faults and reaction
   input wire logic        i_lim_trip, i_ramp_done, o_stage_off,
   input wire logic        o_brake_slow, o_brake_quick, o_psm_vld,
   input wire logic        o_warn, o_lim_pos_vld,
   input wire logic [1:0]  o_psm_state,
   input wire logic [31:0] i_lim_pos, o_lim_pos
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);

   // ****
   // Braking steps
   // ****
   sequence s_braking;
      o_brake_slow || o_brake_quick;
   endsequence
   sequence s_brake_end;
      s_braking ##1 !(o_brake_slow || o_brake_quick);
   endsequence

   chk_brake_final: assert property (s_brake_end |-> o_psm_vld)
      else $error("braking ended without a state request");
   chk_brake_hold: assert property
      ((o_brake_slow || o_brake_quick) && !i_ramp_done
       |=> $stable({o_brake_slow, o_brake_quick}))
      else $error("brake changed before ramp done");
   chk_brake_one: assert property (!(o_brake_slow && o_brake_quick))
      else $error("both ramps selected");
   chk_psm_code: assert property
      (o_psm_vld |-> o_psm_state inside {2'b01, 2'b10})
      else $error("illegal power state request");
   chk_psm_pulse: assert property
      (o_psm_vld ##1 o_psm_vld |=> !o_psm_vld)
      else $error("state request too long");
   chk_off_sod: assert property
      ($rose(o_stage_off) |-> o_psm_vld && o_psm_state == 2'b10)
      else $error("stage off without disable request");
   chk_trip_warn: assert property (i_lim_trip |=> o_warn)
      else $error("warning not set on trip");
   chk_trip_pos: assert property
      (i_lim_trip |=> !o_lim_pos_vld || o_lim_pos == $past(i_lim_pos))
      else $error("wrong latched position");
   chk_write_ans: assert property
      (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:3] o_bvalid)
      else $error("write not answered");
   chk_read_ans: assert property
      (i_arvalid && o_arready |-> ##[1:2] o_rvalid)
      else $error("read not answered");
   chk_resp_hold: assert property
      (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   chk_rdata_hold: assert property
      (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped");
endmodule

bind dfr_top dfr_top_checker chk_i
(
   .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_awvalid(i_awvalid),
   .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
   .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
   .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
   .o_bresp(o_bresp), .o_rdata(o_rdata), .i_lim_trip(i_lim_trip),
   .i_ramp_done(i_ramp_done), .o_stage_off(o_stage_off),
   .o_brake_slow(o_brake_slow), .o_brake_quick(o_brake_quick),
   .o_psm_vld(o_psm_vld), .o_warn(o_warn), .o_lim_pos_vld(o_lim_pos_vld),
   .o_psm_state(o_psm_state), .i_lim_pos(i_lim_pos), .o_lim_pos(o_lim_pos)
);

// *** test/dfr_axi_master.sv ***
// AXI4-Lite master standing in for the fieldbus side.
// Assumes the slave shares its clock; the bench calls wr and rd.
`timescale 1ns/1ns

module dfr_axi_master
(
   // Clock
   input  wire logic        i_clk_sys,
   // Write channels and read response
   output logic [17:0]      o_awaddr,
   output logic [31:0]      o_wdata,
   output logic [3:0]       o_wstrb,
   output logic             o_awvalid, o_wvalid, o_bready,
   input  wire logic        i_awready, i_wready, i_bvalid,
   input  wire logic [1:0]  i_bresp, i_rresp,
   // Read channels
   output logic [17:0]      o_araddr,
   output logic             o_arvalid, o_rready,
   input  wire logic        i_arready, i_rvalid,
   input  wire logic [31:0] i_rdata
);
   initial
   begin
      {o_awaddr, o_wdata, o_wstrb, o_awvalid, o_wvalid, o_bready} = '0;
      {o_araddr, o_arvalid, o_rready} = '0;
   end

   // Slow answers now and then, to exercise the slave's hold
   task automatic stall();
      repeat ($urandom_range(0, 2)) @(posedge i_clk_sys);
   endtask

   task automatic wr(input logic [15:0] idx, input logic [31:0] d,
                     output logic [1:0] r);
      bit a;
      bit w;
      a = 0;
      w = 0;
      @(posedge i_clk_sys);
      {o_awaddr, o_wdata, o_wstrb} <= {idx, 2'b00, d, 4'hf};
      {o_awvalid, o_wvalid} <= 2'b11;
      do
      begin
         @(posedge i_clk_sys);
         // Released lines show a changed value, not the stale one
         if (i_awready)
            {o_awvalid, o_awaddr} <= {1'b0, ~o_awaddr};
         if (i_wready)
            {o_wvalid, o_wdata} <= {1'b0, ~o_wdata};
         a |= i_awready;
         w |= i_wready;
      end while (!(a && w));
      stall();
      o_bready <= 1'b1;
      do @(posedge i_clk_sys); while (!i_bvalid);
      r = i_bresp;
      o_bready <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] idx, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge i_clk_sys);
      {o_arvalid, o_araddr} <= {1'b1, idx, 2'b00};
      do @(posedge i_clk_sys); while (!i_arready);
      {o_arvalid, o_araddr} <= {1'b0, ~o_araddr};
      stall();
      o_rready <= 1'b1;
      do @(posedge i_clk_sys); while (!i_rvalid);
      d = i_rdata;
      r = i_rresp;
      o_rready <= 1'b0;
   endtask
endmodule

// *** test/tb_drive_fault_reaction_select.sv ***
// Self-checking bench of the fault reaction block.
// Assumes the master model and the checker are compiled before it.
`timescale 1ns/1ns
`include "dfr_defs.svh"
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin err_total++; \
$display("unexpected at %0t: %s", $time, m); end end

module tb_drive_fault_reaction_select;
   logic        clk_sys = 0, rst = 1, dev = 0, lim = 0, rdone = 0, en = 1;
   logic [31:0] pos = '0, esize = '0, wdata, rdata, lpos;
   logic [17:0] awaddr, araddr;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, pst;
   logic        awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
   logic        soff, bsl, bqk, pv, warn, lpv, irq;
   int          err_total = 0, checked = 0;

   // Clock enable dropped once, while the bus is idle
   dfr_top uut
   (
      .i_clk_sys(clk_sys), .i_reset(rst), .i_clk_en(en),
      .i_awaddr(awaddr), .i_awvalid(awv), .o_awready(awr),
      .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wv), .o_wready(wrdy),
      .o_bresp(bresp), .o_bvalid(bv), .i_bready(br), .i_araddr(araddr),
      .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp),
      .o_rvalid(rv), .i_rready(rr), .i_dev_err(dev), .i_lim_trip(lim),
      .i_lim_pos(pos), .i_ramp_done(rdone), .i_eeprom_size(esize),
      .o_stage_off(soff), .o_brake_slow(bsl), .o_brake_quick(bqk),
      .o_psm_vld(pv), .o_psm_state(pst), .o_warn(warn), .o_lim_pos(lpos),
      .o_lim_pos_vld(lpv), .o_irq(irq)
   );
   dfr_axi_master mst
   (
      .i_clk_sys(clk_sys), .o_awaddr(awaddr), .o_wdata(wdata),
      .o_wstrb(wstrb), .o_awvalid(awv), .o_wvalid(wv), .o_bready(br),
      .i_awready(awr), .i_wready(wrdy), .i_bvalid(bv), .i_bresp(bresp),
      .i_rresp(rresp), .o_araddr(araddr), .o_arvalid(arv),
      .o_rready(rr), .i_arready(arr), .i_rvalid(rv), .i_rdata(rdata)
   );

   initial
   begin
      forever #2 clk_sys = ~clk_sys;
   end

   // ****
   // Tasks
   // ****
   task automatic wreg(input logic [15:0] i, input logic [31:0] d,
                       input logic [1:0] er);
      logic [1:0] r;
      mst.wr(i, d, r);
      `CHK(r, er, "write response")
   endtask
   task automatic rreg(input logic [15:0] i, input logic [31:0] ev,
                       input logic [1:0] er);
      logic [1:0]  r;
      logic [31:0] d;
      mst.rd(i, d, r);
      `CHK(r, er, "read response")
      `CHK(d, ev, "read data")
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic pulse(input bit l, input logic [31:0] p);
      @(posedge clk_sys);
      {lim, dev, pos} <= {l, !l, p};
      @(posedge clk_sys);
      {lim, dev, pos} <= {2'b00, ~p};
   endtask
   task automatic clr();
      wreg(`DFR_IDX_CTL, 32'h1, `DFR_OKAY);
      wreg(`DFR_IDX_IST, 32'h7, `DFR_OKAY);
      settle(2);
      `CHK({irq, soff, warn}, 3'b000, "clear")
   endtask
   // Model: expected request queue and outputs from the option code
   task automatic react(input bit l, input int code);
      logic [1:0]  q[$];
      logic [1:0]  e[$];
      logic [31:0] p;
      bit          slow, quick, sod;
      p = $urandom;
      slow = code == 1 || (l && code == 5);
      quick = code == 2 || (l && code == 6);
      sod = code inside {0, 1, 2};
      if (l && (sod || slow || quick))
         e.push_back(2'b01);
      if (sod || slow || quick)
         e.push_back(sod ? 2'b10 : 2'b01);
      pulse(l, p);
      for (int n = 0; n < 30; n++)
      begin
         @(negedge clk_sys);
         if (pv)
            q.push_back(pst);
         if (n == 4)
            `CHK({bsl, bqk}, {slow, quick}, "brake")
         @(posedge clk_sys);
         rdone <= (n == 8);
      end
      @(negedge clk_sys);
      `CHK(q.size(), e.size(), "request count")
      foreach (e[i])
         `CHK(q[i], e[i], "request state")
      `CHK(soff, sod, "stage off")
      `CHK(warn, l, "warning")
      `CHK(irq, 1'b1, "irq")
      if (l)
         `CHK(lpv, code != -2, "position valid")
      if (l && code != -2)
         `CHK(lpos, p, "position")
      if (l && code != -2)
         rreg(`DFR_IDX_LPOS, p, `DFR_OKAY);
      clr();
   endtask

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ****
   // Tests
   // ****
   initial
   begin
      int          lc[8] = '{-2, -1, 0, 1, 2, 5, 6, 3};
      int          dc[5] = '{-1, 0, 1, 2, 5};
      logic [31:0] v;
      v = $urandom(20495);
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rreg(`DFR_IDX_DEV, 32'h0000_ffff, `DFR_OKAY);
      rreg(`DFR_IDX_LIM, 32'h0000_ffff, `DFR_OKAY);
      rreg(`DFR_IDX_HWC, `DFR_RST_HWC, `DFR_OKAY);
      v = $urandom;
      wreg(`DFR_IDX_HWC, v, `DFR_OKAY);
      rreg(`DFR_IDX_HWC, v, `DFR_OKAY);
      esize <= v;
      wreg(`DFR_IDX_EEP, ~v, `DFR_OKAY);
      rreg(`DFR_IDX_EEP, v, `DFR_OKAY);
      esize <= '0;
      rreg(`DFR_IDX_EEP, 32'h0, `DFR_OKAY);
      wreg(16'h0100, v, `DFR_SLVERR);
      rreg(16'h0100, 32'h0, `DFR_SLVERR);
      wreg(`DFR_IDX_DEV, v | 32'h8000, `DFR_OKAY);
      rreg(`DFR_IDX_DEV, {16'h0, v[15:0] | 16'h8000}, `DFR_OKAY);
      $display("test registers done");
      wreg(`DFR_IDX_IMSK, 32'h0, `DFR_OKAY);
      pulse(1'b0, v);
      settle(3);
      `CHK(irq, 1'b0, "masked irq")
      wreg(`DFR_IDX_IMSK, 32'h7, `DFR_OKAY);
      settle(3);
      `CHK(irq, 1'b1, "unmasked irq")
      clr();
      @(posedge clk_sys);
      en <= 1'b0;
      pulse(1'b0, v);
      @(posedge clk_sys);
      en <= 1'b1;
      settle(2);
      `CHK(irq, 1'b0, "frozen event")
      $display("test interrupt done");
      foreach (lc[i])
      begin
         wreg(`DFR_IDX_LIM, {16'h0, 16'(lc[i])}, `DFR_OKAY);
         rreg(`DFR_IDX_LIM, {16'h0, 16'(lc[i])}, `DFR_OKAY);
         react(1'b1, lc[i]);
      end
      $display("test limit reactions done");
      foreach (dc[i])
      begin
         wreg(`DFR_IDX_DEV, {16'h0, 16'(dc[i])}, `DFR_OKAY);
         react(1'b0, dc[i]);
      end
      $display("test deviation reactions done");
      print_verdict();
   end

   initial
   begin
      #(4 * 20000);
      err_total++;
      $display("unexpected at %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule
